// ---- include/tpc_pkg.sv ----
// ----------------------------------------------------------------
// Program trace capture shared constants
// ----------------------------------------------------------------
package tpc_pkg;

    // Trace memory geometry
    localparam int TPC_DEPTH = 64;
    localparam int TPC_LINE_W = 20;
    localparam int TPC_PTR_W = 6;
    localparam int TPC_CNT_W = 7;
    localparam int TPC_ADDR_W = 18;

    // Line layout: field 2 on top, then field 1 and field 0
    localparam int TPC_F2_LSB = 16;
    localparam int TPC_F1_LSB = 8;
    localparam int TPC_F0_LSB = 0;

    // Field 2 information bits
    localparam int TPC_BIT_SIZE = 3;
    localparam int TPC_BIT_DIR = 2;
    localparam int TPC_BIT_SD = 3;
    localparam int TPC_BIT_VEC = 2;

    // Compressed row: two information bits above 18 address bits
    localparam logic [1:0] TPC_INF_BASE = 2'h0;
    localparam logic [1:0] TPC_INF_ONE = 2'h1;
    localparam logic [1:0] TPC_INF_TWO = 2'h2;
    localparam logic [1:0] TPC_INF_THREE = 2'h3;
    localparam int TPC_PC_BLK_LSB = 6;

    // Register byte offsets
    localparam logic [3:0] TPC_OFS_CTRL = 4'h0;
    localparam logic [3:0] TPC_OFS_STATUS = 4'h4;
    localparam logic [3:0] TPC_OFS_LINESEL = 4'h8;
    localparam logic [3:0] TPC_OFS_LINEDATA = 4'hc;

    // Control register fields
    localparam int TPC_CTRL_EN = 0;
    localparam int TPC_CTRL_MODE_LSB = 1;
    localparam int TPC_CTRL_ARM = 3;

    // Status register fields
    localparam int TPC_STAT_ARMED = 8;
    localparam int TPC_STAT_WRAP = 9;

    // Values after reset
    localparam logic [1:0] TPC_MODE_RST = 2'h0;
    localparam logic TPC_EN_RST = 1'b0;
    localparam logic [TPC_CNT_W-1:0] TPC_CNT_RST = 7'h00;
    localparam logic [TPC_PTR_W-1:0] TPC_PTR_RST = 6'h00;

    // Trace modes
    typedef enum logic [1:0] {
        TPC_MODE_FLOW,
        TPC_MODE_LOOP,
        TPC_MODE_DETAIL,
        TPC_MODE_CPC
    } tpc_mode_t;

    // Instruction class reported by the core at completion
    typedef enum logic [3:0] {
        TPC_FK_NONE,
        TPC_FK_COND_TAKEN,
        TPC_FK_LOOP_TAKEN,
        TPC_FK_IDX_JUMP,
        TPC_FK_RETURN,
        TPC_FK_VECTOR,
        TPC_FK_BGD_VECTOR,
        TPC_FK_UNCOND_BR,
        TPC_FK_BR_SUB,
        TPC_FK_BGND,
        TPC_FK_DIRECT_JUMP
    } tpc_flow_t;

endpackage

// ---- logic/tpc_trace_mem.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Trace memory: two write ports, one registered read port
// ----------------------------------------------------------------
module tpc_trace_mem #(
    parameter int DEPTH = 64,
    parameter int WIDTH = 20,
    parameter int AW = 6
) (
    // Clock
    input wire logic clock,
    // Write port a
    input wire logic we_a,
    input wire logic [AW-1:0] addr_a,
    input wire logic [WIDTH-1:0] din_a,
    // Write port b
    input wire logic we_b,
    input wire logic [AW-1:0] addr_b,
    input wire logic [WIDTH-1:0] din_b,
    // Read port
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    // No reset: contents survive a system reset
    always_ff @(posedge clock)
    begin
        if (we_a)
            mem[addr_a] <= din_a;
        if (we_b)
            mem[addr_b] <= din_b;
    end

    // Registered read
    always_ff @(posedge clock)
    begin
        rdata <= mem[raddr];
    end

endmodule

// ---- logic/tpc_trace_capture.sv ----
`timescale 1ns/1ps
// How it works
// - End aligned: keep storing until final state, then disarm, store no more.
// - A trigger coinciding with a flow-change record is not stored.
// - After the last line the write pointer wraps and overwrites oldest.
// - Four modes from trace_mode_select; capture only with source enabled.
// - Flow mode stores taken branch sources, indexed/return destinations, vectors.
// - Unconditional, subroutine branch, background, direct jumps are ignored.
// - A flow record holds the full 18-bit address plus info bits.
// - Destination stored at instruction completion, even with an interrupt.
// - Loop mode keeps a shadow of the last stored address.
// - Loop mode suppresses only repeated sources, never destinations.
// - Detailed mode stores every access except free and opcode fetch.
// - Compressed mode stores the PC of every executed opcode.
// - Compressed rows: 2 info bits, 18 bits; full base on block change.
// - Detailed entries take two lines; counter advances twice.
// - Byte data goes to the low data byte, high byte cleared.
// - Word data: lower-address byte to byte 1, higher to byte 0.
// - Line is 4-bit field 2 over two 8-bit fields.
// - Detailed field 2: bit 3 size, bits 1:0 address 17:16.
// - Detailed field 2 bit 2: 0 write, 1 read.
// - Flow field 2: bit 3 source/dest, bit 2 vector, bits 1:0 PC.
// - A vector record is always marked as destination.
// - Trace memory is 64 lines of 20 bits, circular.
// - Valid-line counter advances with each new line written, holding at 64.
// - No capture while background debug controller is active.
// - New full base when PC 17:6 differs from the previous base.
module tpc_trace_capture (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RESETN,
    // Avalon-MM slave
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // Sequencer and background debug controller
    input wire logic SEQ_FINAL,
    input wire logic BDM_ACTIVE,
    // Completed flow-change instructions
    input wire logic FLOW_VALID,
    input wire tpc_pkg::tpc_flow_t FLOW_KIND,
    input wire logic [tpc_pkg::TPC_ADDR_W-1:0] FLOW_ADDR,
    // Executed opcodes
    input wire logic OPC_VALID,
    input wire logic [tpc_pkg::TPC_ADDR_W-1:0] OPC_PC,
    // Bus cycles
    input wire logic ACC_VALID,
    input wire logic [tpc_pkg::TPC_ADDR_W-1:0] ACC_ADDR,
    input wire logic ACC_READ,
    input wire logic ACC_BYTE,
    input wire logic ACC_FREE,
    input wire logic ACC_FETCH,
    input wire logic [15:0] ACC_DATA,
    // Status
    output logic TRACE_ARMED
);
    import tpc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic wait_q;
    logic en_q;
    tpc_mode_t mode_q;
    logic armed_q;
    logic wrap_q;
    logic [TPC_PTR_W-1:0] sel_q;
    logic [TPC_PTR_W-1:0] wptr_q;
    logic [TPC_PTR_W-1:0] wptr_d;
    logic [TPC_CNT_W-1:0] cnt_q;
    logic [TPC_CNT_W-1:0] cnt_d;
    logic [TPC_ADDR_W-1:0] shadow_q;
    logic shadow_vld_q;
    logic [TPC_ADDR_W-1:TPC_PC_BLK_LSB] base_q;
    logic base_vld_q;
    logic [1:0] slot_q;
    logic [1:0] slot_d;
    logic [TPC_PTR_W-1:0] inc_idx_q;
    logic [TPC_ADDR_W-1:0] inc_q;
    logic [TPC_ADDR_W-1:0] inc_d;

    logic ack;
    logic wr_ctrl;
    logic arm_now;
    logic cap;
    logic rec_src;
    logic rec_dst;
    logic rec_vec;
    logic flow_hit;
    logic acc_hit;
    logic opc_hit;
    logic new_base;
    logic [1:0] adv;
    logic we_a;
    logic we_b;
    logic [TPC_PTR_W-1:0] addr_a;
    logic [TPC_LINE_W-1:0] din_a;
    logic [TPC_LINE_W-1:0] din_b;
    logic [TPC_LINE_W-1:0] mem_rdata;

    // ------------------------------------------------------------
    // Avalon slave: one wait state, answer on the second edge
    // ------------------------------------------------------------
    assign ack = (AVS_READ | AVS_WRITE) & ~wait_q;
    assign wr_ctrl = AVS_WRITE & ~wait_q & AVS_BYTEENABLE[0]
                   & (AVS_ADDRESS == TPC_OFS_CTRL);
    assign arm_now = wr_ctrl & AVS_WRITEDATA[TPC_CTRL_ARM] & ~armed_q;

    // Waitrequest drops for exactly one cycle per request
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
            wait_q <= 1'b1;
        else if ((AVS_READ | AVS_WRITE) & wait_q)
            wait_q <= 1'b0;
        else
            wait_q <= 1'b1;
    end

    // Read data loaded as waitrequest falls, unmapped reads give zero
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
            AVS_READDATA <= 32'h0000_0000;
        else if (AVS_READ & wait_q)
        begin
            case (AVS_ADDRESS)
                TPC_OFS_CTRL:
                    AVS_READDATA <= {28'h000_0000, armed_q, mode_q, en_q};
                TPC_OFS_STATUS:
                    AVS_READDATA <= {22'h00_0000, wrap_q, armed_q,
                                     1'b0, cnt_q};
                TPC_OFS_LINESEL:
                    AVS_READDATA <= {26'h000_0000, sel_q};
                TPC_OFS_LINEDATA:
                    AVS_READDATA <= {12'h000, mem_rdata};
                default:
                    AVS_READDATA <= 32'h0000_0000;
            endcase
        end
    end

    assign AVS_WAITREQUEST = wait_q;

    // Control: enable and trace_mode_select
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            en_q <= TPC_EN_RST;
            mode_q <= tpc_mode_t'(TPC_MODE_RST);
        end
        else if (wr_ctrl)
        begin
            en_q <= AVS_WRITEDATA[TPC_CTRL_EN];
            mode_q <= tpc_mode_t'(AVS_WRITEDATA[TPC_CTRL_MODE_LSB +: 2]);
        end
    end

    // Line selector for the read-back window
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
            sel_q <= TPC_PTR_RST;
        else if (AVS_WRITE & ~wait_q & AVS_BYTEENABLE[0]
                 & (AVS_ADDRESS == TPC_OFS_LINESEL))
            sel_q <= AVS_WRITEDATA[TPC_PTR_W-1:0];
    end

    // ------------------------------------------------------------
    // Arming: a write arms, final state or a write of zero disarms
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
            armed_q <= 1'b0;
        else if (wr_ctrl)
            armed_q <= AVS_WRITEDATA[TPC_CTRL_ARM];
        else if (SEQ_FINAL)
            armed_q <= 1'b0;
    end

    assign TRACE_ARMED = armed_q;

    // ------------------------------------------------------------
    // Capture qualification and event decode
    // ------------------------------------------------------------
    // Final-state cycle stores nothing, so a coinciding record is lost
    assign cap = armed_q & en_q & ~BDM_ACTIVE & ~SEQ_FINAL;

    // Only these classes count as flow changes
    assign rec_src = (FLOW_KIND == TPC_FK_COND_TAKEN)
                   | (FLOW_KIND == TPC_FK_LOOP_TAKEN);
    assign rec_dst = (FLOW_KIND == TPC_FK_IDX_JUMP)
                   | (FLOW_KIND == TPC_FK_RETURN);
    // Background-debug vectors and plain jumps fall through here
    assign rec_vec = (FLOW_KIND == TPC_FK_VECTOR);

    // Loop filter drops a source equal to the shadow only
    assign flow_hit = cap & FLOW_VALID & (rec_src | rec_dst | rec_vec)
                    & (mode_q == TPC_MODE_FLOW | mode_q == TPC_MODE_LOOP)
                    & ~(mode_q == TPC_MODE_LOOP & rec_src & shadow_vld_q
                        & FLOW_ADDR == shadow_q);

    assign acc_hit = cap & ACC_VALID & ~ACC_FREE & ~ACC_FETCH
                   & (mode_q == TPC_MODE_DETAIL);

    assign opc_hit = cap & OPC_VALID & (mode_q == TPC_MODE_CPC);

    // First line of the buffer always holds a base
    assign new_base = ~base_vld_q
                    | (OPC_PC[TPC_ADDR_W-1:TPC_PC_BLK_LSB] != base_q)
                    | (slot_q == 2'h0 & wptr_q == TPC_PTR_RST);

    // ------------------------------------------------------------
    // Line assembly
    // ------------------------------------------------------------
    always_comb
    begin
        we_a = 1'b0;
        we_b = 1'b0;
        addr_a = wptr_q;
        din_a = '0;
        din_b = '0;
        adv = 2'h0;
        slot_d = slot_q;
        inc_d = inc_q;
        if (flow_hit)
        begin
            // One line per record, vector forces destination
            we_a = 1'b1;
            adv = 2'h1;
            din_a[TPC_F2_LSB + TPC_BIT_SD] = rec_dst | rec_vec;
            din_a[TPC_F2_LSB + TPC_BIT_VEC] = rec_vec;
            din_a[TPC_ADDR_W-1:0] = FLOW_ADDR;
        end
        else if (acc_hit)
        begin
            // Address line then data line, written together
            we_a = 1'b1;
            we_b = 1'b1;
            adv = 2'h2;
            din_a[TPC_F2_LSB + TPC_BIT_SIZE] = ACC_BYTE;
            din_a[TPC_F2_LSB + TPC_BIT_DIR] = ACC_READ;
            din_a[TPC_ADDR_W-1:0] = ACC_ADDR;
            if (ACC_BYTE)
                din_b[TPC_F0_LSB +: 8] = ACC_DATA[7:0];
            else
                din_b[TPC_F0_LSB +: 16] = ACC_DATA;
        end
        else if (opc_hit)
        begin
            we_a = 1'b1;
            if (new_base)
            begin
                // Full 18-bit PC with base code
                din_a = {TPC_INF_BASE, OPC_PC};
                adv = 2'h1;
                slot_d = 2'h0;
            end
            else
            begin
                // Low six bits packed into the open row
                case (slot_q)
                    2'h0:
                    begin
                        inc_d = {12'h000, OPC_PC[5:0]};
                        din_a = {TPC_INF_ONE, inc_d};
                        adv = 2'h1;
                        slot_d = 2'h1;
                    end
                    2'h1:
                    begin
                        inc_d = {6'h00, OPC_PC[5:0], inc_q[5:0]};
                        din_a = {TPC_INF_TWO, inc_d};
                        addr_a = inc_idx_q;
                        slot_d = 2'h2;
                    end
                    default:
                    begin
                        inc_d = {OPC_PC[5:0], inc_q[11:0]};
                        din_a = {TPC_INF_THREE, inc_d};
                        addr_a = inc_idx_q;
                        slot_d = 2'h0;
                    end
                endcase
            end
        end
    end

    // Pointer and counter advance; counter stops at full depth
    always_comb
    begin
        wptr_d = wptr_q + TPC_PTR_W'(adv);
        if ({1'b0, cnt_q} + {6'h00, adv} > TPC_CNT_W'(TPC_DEPTH) + 8'h00)
            cnt_d = TPC_CNT_W'(TPC_DEPTH);
        else
            cnt_d = cnt_q + TPC_CNT_W'(adv);
    end

    // ------------------------------------------------------------
    // Write pointer, valid-line counter and wrap flag
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            wptr_q <= TPC_PTR_RST;
            cnt_q <= TPC_CNT_RST;
            wrap_q <= 1'b0;
        end
        else if (arm_now)
        begin
            wptr_q <= TPC_PTR_RST;
            cnt_q <= TPC_CNT_RST;
            wrap_q <= 1'b0;
        end
        else if (adv != 2'h0)
        begin
            wptr_q <= wptr_d;
            cnt_q <= cnt_d;
            if (wptr_d < wptr_q)
                wrap_q <= 1'b1;
        end
    end

    // Loop shadow follows every stored flow address
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            shadow_q <= '0;
            shadow_vld_q <= 1'b0;
        end
        else if (arm_now)
            shadow_vld_q <= 1'b0;
        else if (flow_hit)
        begin
            shadow_q <= FLOW_ADDR;
            shadow_vld_q <= 1'b1;
        end
    end

    // Compressed base and open row tracking
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            base_q <= '0;
            base_vld_q <= 1'b0;
            slot_q <= 2'h0;
            inc_idx_q <= TPC_PTR_RST;
            inc_q <= '0;
        end
        else if (arm_now)
        begin
            base_vld_q <= 1'b0;
            slot_q <= 2'h0;
        end
        else if (opc_hit)
        begin
            slot_q <= slot_d;
            inc_q <= inc_d;
            if (new_base)
            begin
                base_q <= OPC_PC[TPC_ADDR_W-1:TPC_PC_BLK_LSB];
                base_vld_q <= 1'b1;
            end
            else if (slot_q == 2'h0)
                inc_idx_q <= wptr_q;
        end
    end

    // ------------------------------------------------------------
    // Trace memory
    // ------------------------------------------------------------
    // Reset never reaches the array so a session survives it
    tpc_trace_mem #(
        .DEPTH(TPC_DEPTH),
        .WIDTH(TPC_LINE_W),
        .AW(TPC_PTR_W)
    ) u_mem (
        .clock(CLOCK),
        .we_a(we_a),
        .addr_a(addr_a),
        .din_a(din_a),
        .we_b(we_b),
        .addr_b(wptr_q + TPC_PTR_W'(1)),
        .din_b(din_b),
        .raddr(sel_q),
        .rdata(mem_rdata)
    );

endmodule

// ---- verification/tpc_core_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Core side: completions, opcodes, bus cycles
// ----------------------------------------
module tpc_core_model (
    // Clock
    input wire logic clock,
    // Flow-change completions
    output logic flow_valid,
    output tpc_pkg::tpc_flow_t flow_kind,
    output logic [17:0] flow_addr,
    // Executed opcodes
    output logic opc_valid,
    output logic [17:0] opc_pc,
    // Bus cycles
    output logic acc_valid,
    output logic [17:0] acc_addr,
    output logic acc_read,
    output logic acc_byte,
    output logic acc_free,
    output logic acc_fetch,
    output logic [15:0] acc_data
);
    import tpc_pkg::*;
    // Quiet core at time zero
    initial
    begin
        {flow_valid, opc_valid, acc_valid} = 3'h0;
        {acc_read, acc_byte, acc_free, acc_fetch} = 4'h0;
        flow_kind = TPC_FK_NONE;
        {flow_addr, opc_pc, acc_addr, acc_data} = 70'h0;
    end
    // Completion reported once the instruction ends, interrupt or not
    task automatic flow(input tpc_flow_t k, input logic [17:0] a);
        @(posedge clock);
        flow_valid <= 1'b1;
        flow_kind <= k;
        flow_addr <= a;
        @(posedge clock);
        flow_valid <= 1'b0;
        flow_addr <= ~a; // Stale value must not be reused
    endtask
    // One executed opcode
    task automatic opc(input logic [17:0] pc);
        @(posedge clock);
        opc_valid <= 1'b1;
        opc_pc <= pc;
        @(posedge clock);
        opc_valid <= 1'b0;
        opc_pc <= ~pc;
    endtask
    // One bus cycle; flags say read, byte, free, fetch
    task automatic acc(input logic [17:0] a, input logic [3:0] f,
        input logic [15:0] d);
        @(posedge clock);
        acc_valid <= 1'b1;
        acc_addr <= a;
        {acc_read, acc_byte, acc_free, acc_fetch} <= f;
        acc_data <= d;
        @(posedge clock);
        acc_valid <= 1'b0;
        acc_addr <= ~a;
        acc_data <= ~d;
    endtask
endmodule

// ---- verification/tpc_trace_capture_sva.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Bus handshake and arming checks
// ----------------------------------------
module tpc_trace_capture_sva (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RESETN,
    // Register bus
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    // Trigger and status
    input wire logic SEQ_FINAL,
    input wire logic TRACE_ARMED
);
    import tpc_pkg::*;
    logic req;
    logic arm_wr;
    // Arm write outranks final state
    assign req = AVS_READ || AVS_WRITE;
    assign arm_wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0]
        && AVS_ADDRESS == TPC_OFS_CTRL && AVS_WRITEDATA[TPC_CTRL_ARM];
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (!RESETN);
    a_wait_one:
        assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("no answer after one wait state");
    a_wait_pulse:
        assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low too long");
    a_wait_cause:
        assert property (!AVS_WAITREQUEST |-> $past(req))
        else $error("answer without request");
    a_idle_wait:
        assert property (!req |=> AVS_WAITREQUEST)
        else $error("answer after idle cycle");
    a_rdata_hold:
        assert property ($changed(AVS_READDATA) |-> $past(AVS_READ))
        else $error("read data changed without a read");
    a_final_disarm:
        assert property (SEQ_FINAL && !arm_wr |=> !TRACE_ARMED)
        else $error("still armed after final state");
    a_armed_rise:
        assert property ($rose(TRACE_ARMED) |-> $past(arm_wr))
        else $error("armed without an arm write");
    a_armed_fall:
        assert property ($fell(TRACE_ARMED)
            |-> $past(SEQ_FINAL || (AVS_WRITE && !AVS_WAITREQUEST)))
        else $error("disarm without cause");
endmodule
bind tpc_trace_capture tpc_trace_capture_sva u_sva (.*);

// ---- verification/tb.sv ----
`timescale 1ns/1ps
module tb;
    import tpc_pkg::*;
    logic CLOCK, RESETN, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
    logic SEQ_FINAL, BDM_ACTIVE, TRACE_ARMED;
    logic [3:0] AVS_ADDRESS, AVS_BYTEENABLE;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd;
    logic FLOW_VALID, OPC_VALID, ACC_VALID, ACC_READ, ACC_BYTE;
    logic ACC_FREE, ACC_FETCH;
    tpc_flow_t FLOW_KIND;
    logic [17:0] FLOW_ADDR, OPC_PC, ACC_ADDR;
    logic [15:0] ACC_DATA;
    int bad_count = 0;
    int checked = 0;
    tpc_trace_capture u_tpc_trace_capture (
        .CLOCK(CLOCK), .RESETN(RESETN), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .SEQ_FINAL(SEQ_FINAL), .BDM_ACTIVE(BDM_ACTIVE),
        .FLOW_VALID(FLOW_VALID), .FLOW_KIND(FLOW_KIND),
        .FLOW_ADDR(FLOW_ADDR), .OPC_VALID(OPC_VALID), .OPC_PC(OPC_PC),
        .ACC_VALID(ACC_VALID), .ACC_ADDR(ACC_ADDR), .ACC_READ(ACC_READ),
        .ACC_BYTE(ACC_BYTE), .ACC_FREE(ACC_FREE), .ACC_FETCH(ACC_FETCH),
        .ACC_DATA(ACC_DATA), .TRACE_ARMED(TRACE_ARMED)
    );
    tpc_core_model u_tpc_core_model (
        .clock(CLOCK), .flow_valid(FLOW_VALID), .flow_kind(FLOW_KIND),
        .flow_addr(FLOW_ADDR), .opc_valid(OPC_VALID), .opc_pc(OPC_PC),
        .acc_valid(ACC_VALID), .acc_addr(ACC_ADDR), .acc_read(ACC_READ),
        .acc_byte(ACC_BYTE), .acc_free(ACC_FREE), .acc_fetch(ACC_FETCH),
        .acc_data(ACC_DATA)
    );
    // 40 MHz clock
    initial
    begin
        CLOCK = 1'b0;
        forever #12.5 CLOCK = ~CLOCK;
    end
    // Request held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [31:0] d = 32'h0, input logic [3:0] be = 4'hf);
        @(posedge CLOCK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_BYTEENABLE <= be;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'b0);
        rd = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] s);
        checked++;
        if (s !== e)
        begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    // Control word: arm, mode, enable
    task automatic ctl(input logic a, input logic en, input tpc_mode_t m);
        bus(1'b1, TPC_OFS_CTRL, {28'h0, a, m, en});
    endtask
    // Counter, armed and wrap fields only
    task automatic stat_chk(input logic [31:0] e);
        bus(1'b0, TPC_OFS_STATUS);
        chk("status", e, rd & 32'h37f);
    endtask
    // Select a line, then read it back
    task automatic line_chk(input int i, input logic [19:0] m,
        input logic [19:0] e);
        bus(1'b1, TPC_OFS_LINESEL, 32'(i));
        bus(1'b0, TPC_OFS_LINEDATA);
        chk("line", {12'h0, e & m}, rd & {12'h0, m});
    endtask
    task automatic t_reset;
        bus(1'b0, TPC_OFS_CTRL);
        chk("ctrl", 32'h0, rd);
        stat_chk(32'h0);
        bus(1'b1, TPC_OFS_CTRL, 32'h5, 4'he);
        bus(1'b0, TPC_OFS_CTRL);
        chk("ctrl", 32'h0, rd);
        bus(1'b1, 4'h2, 32'hf);
        bus(1'b0, 4'h2);
        chk("unmapped", 32'h0, rd);
        ctl(1'b0, 1'b1, TPC_MODE_LOOP);
        bus(1'b0, TPC_OFS_CTRL);
        chk("ctrl", 32'h3, rd);
        $display("test reset done");
    endtask
    task automatic t_flow;
        ctl(1'b1, 1'b1, TPC_MODE_FLOW);
        for (int k = 1; k <= 10; k++)
            u_tpc_core_model.flow(tpc_flow_t'(k), 18'h2c000 + 18'(k));
        BDM_ACTIVE <= 1'b1;
        u_tpc_core_model.flow(TPC_FK_COND_TAKEN, 18'h2c0ff);
        BDM_ACTIVE <= 1'b0;
        stat_chk(32'h105);
        ctl(1'b0, 1'b1, TPC_MODE_FLOW);
        for (int k = 1; k <= 5; k++)
            line_chk(k - 1, 20'hfffff, {k < 3 ? 4'h2 : k < 5 ? 4'ha : 4'he,
                16'hc000 + 16'(k)});
        ctl(1'b1, 1'b0, TPC_MODE_FLOW);
        u_tpc_core_model.flow(TPC_FK_COND_TAKEN, 18'h00001);
        stat_chk(32'h100);
        ctl(1'b0, 1'b0, TPC_MODE_FLOW);
        $display("test flow done");
    endtask
    task automatic t_loop;
        ctl(1'b1, 1'b1, TPC_MODE_LOOP);
        for (int k = 0; k < 5; k++)
            u_tpc_core_model.flow(k / 2 == 1 ? TPC_FK_IDX_JUMP
                : TPC_FK_COND_TAKEN, 18'h01000 | 18'(k / 2 == 1) << 8);
        stat_chk(32'h104);
        ctl(1'b0, 1'b1, TPC_MODE_LOOP);
        line_chk(2, 20'hfffff, 20'h81100);
        line_chk(3, 20'hfffff, 20'h01000);
        $display("test loop done");
    endtask
    task automatic t_detail;
        ctl(1'b1, 1'b1, TPC_MODE_DETAIL);
        u_tpc_core_model.acc(18'h3abcd, 4'h8, 16'h1234);
        u_tpc_core_model.acc(18'h00020, 4'ha, 16'h1111);
        u_tpc_core_model.acc(18'h00030, 4'h9, 16'h2222);
        u_tpc_core_model.acc(18'h10010, 4'h4, 16'hff56);
        stat_chk(32'h104);
        ctl(1'b0, 1'b1, TPC_MODE_DETAIL);
        line_chk(0, 20'hfffff, 20'h7abcd);
        line_chk(1, 20'h0ffff, 20'h01234);
        line_chk(2, 20'hfffff, 20'h90010);
        line_chk(3, 20'h0ffff, 20'h00056);
        $display("test detail done");
    endtask
    task automatic t_cpc;
        ctl(1'b1, 1'b1, TPC_MODE_CPC);
        for (int k = 0; k < 4; k++)
            u_tpc_core_model.opc(k < 3 ? 18'h00100 + 18'(4 * k) : 18'h00200);
        ctl(1'b0, 1'b1, TPC_MODE_CPC);
        line_chk(0, 20'hfffff, 20'h00100);
        line_chk(1, 20'hfffff, 20'h80204);
        line_chk(2, 20'hfffff, 20'h00200);
        $display("test compressed done");
    endtask
    task automatic t_wrap;
        ctl(1'b1, 1'b1, TPC_MODE_FLOW);
        for (int k = 0; k <= 64; k++)
            u_tpc_core_model.flow(TPC_FK_COND_TAKEN, 18'(k));
        stat_chk(32'h340);
        ctl(1'b0, 1'b1, TPC_MODE_FLOW);
        line_chk(0, 20'hfffff, 20'h00040);
        line_chk(1, 20'hfffff, 20'h00001);
        $display("test wrap done");
    endtask
    // Record in the final cycle is dropped, later ones too
    task automatic t_final;
        ctl(1'b1, 1'b1, TPC_MODE_FLOW);
        u_tpc_core_model.flow(TPC_FK_COND_TAKEN, 18'h00005);
        fork
            u_tpc_core_model.flow(TPC_FK_COND_TAKEN, 18'h00006);
            begin
                @(posedge CLOCK);
                SEQ_FINAL <= 1'b1;
                @(posedge CLOCK);
                SEQ_FINAL <= 1'b0;
            end
        join
        u_tpc_core_model.flow(TPC_FK_COND_TAKEN, 18'h00007);
        stat_chk(32'h001);
        line_chk(0, 20'hfffff, 20'h00005);
        $display("test final done");
    endtask
    task automatic close_out;
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        RESETN = 1'b0;
        {AVS_READ, AVS_WRITE, SEQ_FINAL, BDM_ACTIVE} = 4'h0;
        {AVS_ADDRESS, AVS_BYTEENABLE, AVS_WRITEDATA} = 40'h0f_0000_0000;
        repeat (10) @(posedge CLOCK);
        RESETN <= 1'b1;
        t_reset;
        t_flow;
        t_loop;
        t_detail;
        t_cpc;
        t_wrap;
        t_final;
        close_out;
    end
    // Run needs about four hundred cycles
    initial
    begin
        repeat (20000) @(posedge CLOCK);
        bad_count++;
        close_out;
    end
endmodule
